// File: design/pmx_pkg.sv
// constants shared by the port alternate-function multiplexer
package pmx_pkg;

   // apb register byte offsets
   localparam logic [7:0] ADDR_PORT3_LATCH  = 8'h00;
   localparam logic [7:0] ADDR_PORT3_DIR    = 8'h04;
   localparam logic [7:0] ADDR_PORT4_LATCH  = 8'h08;
   localparam logic [7:0] ADDR_PORT4_DIR    = 8'h0c;
   localparam logic [7:0] ADDR_PORT4_OD     = 8'h10;
   localparam logic [7:0] ADDR_PORT5_LATCH  = 8'h14;
   localparam logic [7:0] ADDR_MODE         = 8'h18;
   localparam logic [7:0] ADDR_PIN_LEVEL    = 8'h1c;

   // port-3 field positions inside the port-3 registers
   localparam int PORT3_PIN6_BIT = 6;
   localparam int PORT3_PIN7_BIT = 7;
   // port-5 pin 0 field position
   localparam int PORT5_PIN0_BIT = 0;
   // mode register: external-bus mode flag
   localparam int MODE_EXT_BUS_BIT = 0;
   // pin level readback field positions
   localparam int LVL_PORT3_PIN6_BIT = 6;
   localparam int LVL_PORT3_PIN7_BIT = 7;
   localparam int LVL_PORT4_LSB      = 8;
   localparam int LVL_PORT5_PIN0_BIT = 16;

   // port-4 pin roles
   localparam int P4_ASYNC_CLK  = 0;
   localparam int P4_ASYNC_TXD  = 1;
   localparam int P4_ASYNC_RXD  = 2;
   localparam int P4_SYNC1_CLK  = 3;
   localparam int P4_SYNC1_TXD  = 4;
   localparam int P4_SYNC1_RXD  = 5;
   localparam int P4_CONV_TRIG  = 6;
   localparam int P4_SYNC0_CLK  = 7;

   // reset values
   localparam logic [7:0]  RST_LATCH      = 8'h00;
   localparam logic [7:0]  RST_DIR        = 8'h00;
   localparam logic [7:0]  RST_OD         = 8'h00;
   localparam logic        RST_PORT5_LAT  = 1'b1;
   localparam logic        RST_EXT_BUS    = 1'b0;
   localparam logic [31:0] RDATA_ZERO     = 32'h0000_0000;

endpackage

// File: design/pmx_pin_cell.sv
// one pin driver cell: port latch or alternate function onto a pad
`timescale 1ns/1ps
module pmx_pin_cell #(
   parameter bit NCH_ONLY = 1'b0                // pad has only a pull-down driver
) (
   input  wire logic latch_in,                 // port output latch bit
   input  wire logic dir_in,                   // direction, 1 = output
   input  wire logic od_in,                    // open-drain select
   input  wire logic alt_en_in,                // alternate output enabled
   input  wire logic alt_drv_in,               // alternate output value
   output logic      pad_drv_out,              // value onto the pad
   output logic      pad_oe_out                // pad output enable
);

   logic od_active;
   logic value;

   // open-drain only matters on a pin set for output
   assign od_active = od_in & dir_in;

   // outside NCH_ONLY the alternate function replaces the latch and drives the pad whatever the direction bit
   always_comb begin
      value = alt_en_in ? alt_drv_in : latch_in;
      if (NCH_ONLY) begin
         // wired-and: latch low or alternate low pulls the line down
         pad_drv_out = 1'b0;
         pad_oe_out  = ~latch_in | (alt_en_in & ~alt_drv_in);
      end else if (alt_en_in || dir_in) begin
         pad_drv_out = od_active ? 1'b0 : value;
         pad_oe_out  = od_active ? ~value : 1'b1;
      end else begin
         pad_drv_out = 1'b0;
         pad_oe_out  = 1'b0;
      end
   end

endmodule

// File: design/pmx_in_route.sv
// gated delivery of a pad level to a peripheral input
`timescale 1ns/1ps
module pmx_in_route #(
   parameter bit IDLE = 1'b0                    // level shown while not selected
) (
   input  wire logic en_in,                    // pin is serving this input
   input  wire logic pad_in,                   // pad level
   output logic      level_out                 // level seen by the peripheral
);

   // idle level keeps the peripheral quiet while the pin does other work
   assign level_out = en_in ? pad_in : IDLE;

endmodule

// File: design/pmx_top.sv
// port alternate-function multiplexer with apb configuration registers
`timescale 1ns/1ps
module pmx_top #(
   parameter int ADDR_W = 8                     // apb address width
) (
   input  wire logic              clk_in,                      // system clock
   input  wire logic              rst_n_in,                    // async reset, low
   input  wire logic [ADDR_W-1:0] paddr_in,                    // apb address
   input  wire logic              psel_in,                     // apb select
   input  wire logic              penable_in,                  // apb enable
   input  wire logic              pwrite_in,                   // apb write
   input  wire logic [31:0]       pwdata_in,                   // apb write data
   input  wire logic [3:0]        pstrb_in,                    // apb byte strobes
   output logic      [31:0]       prdata_out,                  // apb read data
   output logic                   pready_out,                  // apb ready
   output logic                   pslverr_out,                 // apb error
   input  wire logic              bus_clock_in,                // bus controller clock
   output logic                   bus_ready_out,               // wait input to bus ctl
   input  wire logic              async_serial_clock_drv_in,   // uart clock value
   input  wire logic              async_serial_clock_en_in,    // uart clock out enable
   output logic                   async_serial_clock_out,      // pin level to uart
   input  wire logic              async_serial_txd_in,         // uart transmit data
   input  wire logic              async_serial_txd_en_in,      // uart data out enable
   output logic                   async_serial_rxd_out,        // uart receive data
   input  wire logic              sync_serial1_clock_drv_in,   // channel 1 clock
   input  wire logic              sync_serial1_clock_en_in,    // channel 1 clock enable
   output logic                   sync_serial1_clock_out,      // pin level to ch 1
   input  wire logic              sync_serial1_txd_in,         // channel 1 tx data
   input  wire logic              sync_serial1_txd_en_in,      // channel 1 tx enable
   output logic                   sync_serial1_rxd_out,        // channel 1 rx data
   input  wire logic              sync_serial0_clock_drv_in,   // channel 0 clock
   input  wire logic              sync_serial0_clock_en_in,    // channel 0 clock enable
   output logic                   sync_serial0_clock_out,      // pin level to ch 0
   input  wire logic              sync_serial0_txd_in,         // channel 0 tx data
   input  wire logic              sync_serial0_txd_en_in,      // channel 0 tx enable
   input  wire logic              converter_ext_trig_sel_in,   // converter uses pin trigger
   output logic                   converter_trigger_in_out,    // trigger level to converter
   input  wire logic              twowire0_data_drv_in,        // two-wire data, 0 pulls low
   input  wire logic              twowire0_en_in,              // two-wire interface active
   output logic                   twowire0_data_out,           // line level to two-wire
   input  wire logic              port3_pin6_in,               // pad level
   output logic                   port3_pin6_out,              // pad drive value
   output logic                   port3_pin6_oe_out,           // pad output enable
   input  wire logic              port3_pin7_in,               // pad level
   output logic                   port3_pin7_out,              // pad drive value
   output logic                   port3_pin7_oe_out,           // pad output enable
   input  wire logic [7:0]        port4_pad_in,                // pad levels
   output logic      [7:0]        port4_pad_out,               // pad drive values
   output logic      [7:0]        port4_pad_oe_out,            // pad output enables
   input  wire logic              port5_pin0_in,               // pad level
   output logic                   port5_pin0_out,              // pad drive value
   output logic                   port5_pin0_oe_out            // pad output enable
);

   ////////////////////////////////////////////////////////////////////////////
   // configuration registers

   logic [7:0]  port3_output_latch_reg, port3_output_latch_next;
   logic [7:0]  port3_direction_reg, port3_direction_next;
   logic [7:0]  port4_output_latch_reg, port4_output_latch_next;
   logic [7:0]  port4_direction_bit_reg, port4_direction_bit_next;
   logic [7:0]  port4_opendrain_reg, port4_opendrain_next;
   logic        port5_output_latch_reg, port5_output_latch_next;
   logic        ext_bus_mode_reg, ext_bus_mode_next;
   logic [31:0] prdata_reg, prdata_next;
   logic        pslverr_reg, pslverr_next;
   logic        setup_phase, wr_take, addr_hit;
   logic [31:0] rd_value, pin_levels;

   // read data is latched in the setup cycle so the access cycle is zero-wait
   assign setup_phase = psel_in & ~penable_in;
   assign wr_take     = psel_in & penable_in & pwrite_in & pstrb_in[0];
   assign pready_out  = psel_in & penable_in;
   assign prdata_out  = prdata_reg;
   assign pslverr_out = pslverr_reg;
   // live pad levels for software
   always_comb begin
      pin_levels = pmx_pkg::RDATA_ZERO;
      pin_levels[pmx_pkg::LVL_PORT3_PIN6_BIT] = port3_pin6_in;
      pin_levels[pmx_pkg::LVL_PORT3_PIN7_BIT] = port3_pin7_in;
      pin_levels[pmx_pkg::LVL_PORT4_LSB +: 8] = port4_pad_in;
      pin_levels[pmx_pkg::LVL_PORT5_PIN0_BIT] = port5_pin0_in;
   end

   // address decode for reads; unmapped offsets read zero with an error
   always_comb begin
      rd_value = pmx_pkg::RDATA_ZERO;
      addr_hit = 1'b1;
      case (paddr_in[7:0])
         pmx_pkg::ADDR_PORT3_LATCH: begin
            rd_value[pmx_pkg::PORT3_PIN6_BIT] = port3_output_latch_reg[pmx_pkg::PORT3_PIN6_BIT];
            rd_value[pmx_pkg::PORT3_PIN7_BIT] = port3_output_latch_reg[pmx_pkg::PORT3_PIN7_BIT];
         end
         pmx_pkg::ADDR_PORT3_DIR: begin
            rd_value[pmx_pkg::PORT3_PIN6_BIT] = port3_direction_reg[pmx_pkg::PORT3_PIN6_BIT];
            rd_value[pmx_pkg::PORT3_PIN7_BIT] = port3_direction_reg[pmx_pkg::PORT3_PIN7_BIT];
         end
         pmx_pkg::ADDR_PORT4_LATCH: rd_value[7:0] = port4_output_latch_reg;
         pmx_pkg::ADDR_PORT4_DIR:   rd_value[7:0] = port4_direction_bit_reg;
         pmx_pkg::ADDR_PORT4_OD:    rd_value[7:0] = port4_opendrain_reg;
         pmx_pkg::ADDR_PORT5_LATCH: rd_value[pmx_pkg::PORT5_PIN0_BIT] = port5_output_latch_reg;
         pmx_pkg::ADDR_MODE:        rd_value[pmx_pkg::MODE_EXT_BUS_BIT] = ext_bus_mode_reg;
         pmx_pkg::ADDR_PIN_LEVEL:   rd_value = pin_levels;
         default:                   addr_hit = 1'b0;
      endcase
   end

   // register writes take effect at the access-phase edge; lane 0 only
   always_comb begin
      port3_output_latch_next  = port3_output_latch_reg;
      port3_direction_next     = port3_direction_reg;
      port4_output_latch_next  = port4_output_latch_reg;
      port4_direction_bit_next = port4_direction_bit_reg;
      port4_opendrain_next     = port4_opendrain_reg;
      port5_output_latch_next  = port5_output_latch_reg;
      ext_bus_mode_next        = ext_bus_mode_reg;
      prdata_next              = prdata_reg;
      pslverr_next             = pslverr_reg;
      if (setup_phase) begin
         prdata_next  = pwrite_in ? pmx_pkg::RDATA_ZERO : rd_value;
         pslverr_next = ~addr_hit;
      end
      if (wr_take) begin
         case (paddr_in[7:0])
            pmx_pkg::ADDR_PORT3_LATCH: begin
               port3_output_latch_next[pmx_pkg::PORT3_PIN6_BIT] =
                  pwdata_in[pmx_pkg::PORT3_PIN6_BIT];
               port3_output_latch_next[pmx_pkg::PORT3_PIN7_BIT] =
                  pwdata_in[pmx_pkg::PORT3_PIN7_BIT];
            end
            pmx_pkg::ADDR_PORT3_DIR: begin
               port3_direction_next[pmx_pkg::PORT3_PIN6_BIT] =
                  pwdata_in[pmx_pkg::PORT3_PIN6_BIT];
               port3_direction_next[pmx_pkg::PORT3_PIN7_BIT] =
                  pwdata_in[pmx_pkg::PORT3_PIN7_BIT];
            end
            pmx_pkg::ADDR_PORT4_LATCH: port4_output_latch_next  = pwdata_in[7:0];
            pmx_pkg::ADDR_PORT4_DIR:   port4_direction_bit_next = pwdata_in[7:0];
            pmx_pkg::ADDR_PORT4_OD:    port4_opendrain_next     = pwdata_in[7:0];
            pmx_pkg::ADDR_PORT5_LATCH: begin
               port5_output_latch_next = pwdata_in[pmx_pkg::PORT5_PIN0_BIT];
            end
            pmx_pkg::ADDR_MODE: ext_bus_mode_next = pwdata_in[pmx_pkg::MODE_EXT_BUS_BIT];
            default: ;
         endcase
      end
   end

   // register stage; port-5 latch resets high so the open-drain line floats
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         port3_output_latch_reg  <= pmx_pkg::RST_LATCH;
         port3_direction_reg     <= pmx_pkg::RST_DIR;
         port4_output_latch_reg  <= pmx_pkg::RST_LATCH;
         port4_direction_bit_reg <= pmx_pkg::RST_DIR;
         port4_opendrain_reg     <= pmx_pkg::RST_OD;
         port5_output_latch_reg  <= pmx_pkg::RST_PORT5_LAT;
         ext_bus_mode_reg        <= pmx_pkg::RST_EXT_BUS;
         prdata_reg              <= pmx_pkg::RDATA_ZERO;
         pslverr_reg             <= 1'b0;
      end else begin
         port3_output_latch_reg  <= port3_output_latch_next;
         port3_direction_reg     <= port3_direction_next;
         port4_output_latch_reg  <= port4_output_latch_next;
         port4_direction_bit_reg <= port4_direction_bit_next;
         port4_opendrain_reg     <= port4_opendrain_next;
         port5_output_latch_reg  <= port5_output_latch_next;
         ext_bus_mode_reg        <= ext_bus_mode_next;
         prdata_reg              <= prdata_next;
         pslverr_reg             <= pslverr_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // pin driver selection

   logic [7:0] p4_alt_en, p4_alt_drv, p4_drv, p4_oe;
   logic       p3_6_drv, p3_6_oe, p3_7_drv, p3_7_oe;
   logic       p5_alt_en, p5_alt_drv, p5_drv, p5_oe;
   // port-4 alternate outputs; unused roles fall back to the port latch
   always_comb begin
      p4_alt_en  = 8'h00;
      p4_alt_drv = 8'h00;
      p4_alt_en[pmx_pkg::P4_ASYNC_CLK]  = async_serial_clock_en_in;
      p4_alt_drv[pmx_pkg::P4_ASYNC_CLK] = async_serial_clock_drv_in;
      p4_alt_en[pmx_pkg::P4_ASYNC_TXD]  = async_serial_txd_en_in;
      p4_alt_drv[pmx_pkg::P4_ASYNC_TXD] = async_serial_txd_in;
      p4_alt_en[pmx_pkg::P4_SYNC1_CLK]  = sync_serial1_clock_en_in;
      p4_alt_drv[pmx_pkg::P4_SYNC1_CLK] = sync_serial1_clock_drv_in;
      p4_alt_en[pmx_pkg::P4_SYNC0_CLK]  = sync_serial0_clock_en_in;
      p4_alt_drv[pmx_pkg::P4_SYNC0_CLK] = sync_serial0_clock_drv_in;
      p4_alt_en[pmx_pkg::P4_SYNC1_TXD]  = sync_serial1_txd_en_in;
      p4_alt_drv[pmx_pkg::P4_SYNC1_TXD] = sync_serial1_txd_in;
   end

   // one cell per port-4 pin; open-drain gated by direction inside the cell
   for (genvar i = 0; i < 8; i++) begin : g_port4
      pmx_pin_cell #(.NCH_ONLY (1'b0)) u_cell (
         .latch_in    (port4_output_latch_reg[i]),
         .dir_in      (port4_direction_bit_reg[i]),
         .od_in       (port4_opendrain_reg[i]),
         .alt_en_in   (p4_alt_en[i]),
         .alt_drv_in  (p4_alt_drv[i]),
         .pad_drv_out (p4_drv[i]),
         .pad_oe_out  (p4_oe[i])
      );
   end

   // pin six: forced to input in external-bus mode to serve as wait input
   pmx_pin_cell #(.NCH_ONLY (1'b0)) u_port3_pin6 (
      .latch_in    (port3_output_latch_reg[pmx_pkg::PORT3_PIN6_BIT]),
      .dir_in      (port3_direction_reg[pmx_pkg::PORT3_PIN6_BIT] & ~ext_bus_mode_reg),
      .od_in       (1'b0),
      .alt_en_in   (1'b0),
      .alt_drv_in  (1'b0),
      .pad_drv_out (p3_6_drv),
      .pad_oe_out  (p3_6_oe)
   );

   // pin seven: bus clock replaces the port function in external-bus mode
   pmx_pin_cell #(.NCH_ONLY (1'b0)) u_port3_pin7 (
      .latch_in    (port3_output_latch_reg[pmx_pkg::PORT3_PIN7_BIT]),
      .dir_in      (port3_direction_reg[pmx_pkg::PORT3_PIN7_BIT]),
      .od_in       (1'b0),
      .alt_en_in   (ext_bus_mode_reg),
      .alt_drv_in  (bus_clock_in),
      .pad_drv_out (p3_7_drv),
      .pad_oe_out  (p3_7_oe)
   );

   // port-5 pin zero: two-wire data and channel-0 data share one pull-down
   assign p5_alt_en  = twowire0_en_in | sync_serial0_txd_en_in;
   assign p5_alt_drv = (~twowire0_en_in | twowire0_data_drv_in) &
                       (~sync_serial0_txd_en_in | sync_serial0_txd_in);

   // a latch left low would hold the line down under the two-wire master
   pmx_pin_cell #(.NCH_ONLY (1'b1)) u_port5_pin0 (
      .latch_in    (port5_output_latch_reg),
      .dir_in      (1'b1),
      .od_in       (1'b1),
      .alt_en_in   (p5_alt_en),
      .alt_drv_in  (p5_alt_drv),
      .pad_drv_out (p5_drv),
      .pad_oe_out  (p5_oe)
   );

   ////////////////////////////////////////////////////////////////////////////
   // peripheral-facing inputs

   logic ready_level, trig_level;
   // outside external-bus mode the bus controller sees ready, never a wait
   pmx_in_route #(.IDLE (1'b1)) u_ready_route (
      .en_in     (ext_bus_mode_reg),
      .pad_in    (port3_pin6_in),
      .level_out (ready_level)
   );

   // trigger stays low unless the converter selected the external source
   pmx_in_route #(.IDLE (1'b0)) u_trig_route (
      .en_in     (converter_ext_trig_sel_in),
      .pad_in    (port4_pad_in[pmx_pkg::P4_CONV_TRIG]),
      .level_out (trig_level)
   );

   ////////////////////////////////////////////////////////////////////////////
   // output register stage
   // every pad and peripheral input is retimed once; costs one cycle of latency
   // on serial clocks but keeps glitches from the select logic off the pins

   logic [7:0] p4_drv_reg, p4_oe_reg;
   logic [4:0] p35_reg, p35_next;
   logic [7:0] periph_reg, periph_next;
   // next values of pad drives and peripheral inputs
   always_comb begin
      p35_next    = {p3_6_drv, p3_6_oe, p3_7_drv, p3_7_oe, p5_oe & ~p5_drv};
      periph_next = {ready_level,
                     port4_pad_in[pmx_pkg::P4_ASYNC_CLK],
                     port4_pad_in[pmx_pkg::P4_ASYNC_RXD],
                     port4_pad_in[pmx_pkg::P4_SYNC1_CLK],
                     port4_pad_in[pmx_pkg::P4_SYNC1_RXD],
                     port4_pad_in[pmx_pkg::P4_SYNC0_CLK],
                     trig_level,
                     port5_pin0_in};
   end

   // drivers start released so no pad fights the board after reset
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         p4_drv_reg <= 8'h00;
         p4_oe_reg  <= 8'h00;
         p35_reg    <= 5'h00;
         periph_reg <= 8'h80;
      end else begin
         p4_drv_reg <= p4_drv;
         p4_oe_reg  <= p4_oe;
         p35_reg    <= p35_next;
         periph_reg <= periph_next;
      end
   end

   assign port4_pad_out            = p4_drv_reg;
   assign port4_pad_oe_out         = p4_oe_reg;
   assign port3_pin6_out           = p35_reg[4];
   assign port3_pin6_oe_out        = p35_reg[3];
   assign port3_pin7_out           = p35_reg[2];
   assign port3_pin7_oe_out        = p35_reg[1];
   assign port5_pin0_out           = 1'b0;
   assign port5_pin0_oe_out        = p35_reg[0];
   assign bus_ready_out            = periph_reg[7];
   assign async_serial_clock_out   = periph_reg[6];
   assign async_serial_rxd_out     = periph_reg[5];
   assign sync_serial1_clock_out   = periph_reg[4];
   assign sync_serial1_rxd_out     = periph_reg[3];
   assign sync_serial0_clock_out   = periph_reg[2];
   assign converter_trigger_in_out = periph_reg[1];
   assign twowire0_data_out        = periph_reg[0];

endmodule

// File: design/pmx_top_fix.sv
// spare unit: holds no logic, the multiplexer sits in pmx_top

// File: testbench/pmx_monitor.sv
// concurrent checks on the multiplexer ports
`timescale 1ns/1ps
module pmx_monitor (
   input wire logic       clk_in, rst_n_in,                             // clock, reset
   input wire logic [7:0] port4_pad_in, port4_pad_out, port4_pad_oe_out, // port 4
   input wire logic       async_serial_clock_en_in, async_serial_clock_drv_in,
   input wire logic       async_serial_txd_en_in, async_serial_txd_in, async_serial_rxd_out,
   input wire logic       sync_serial1_clock_en_in, sync_serial1_clock_drv_in,
   input wire logic       sync_serial0_clock_en_in, sync_serial0_clock_drv_in,
   input wire logic       sync_serial0_txd_en_in, sync_serial0_txd_in,   // channel 0 tx
   input wire logic       port5_pin0_out, port5_pin0_oe_out,             // port 5 pad
   input wire logic       converter_ext_trig_sel_in, converter_trigger_in_out
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);
   ////////////////////////////////////////////////////////////////
   // level of a pulled-up pad: one test fits push-pull and open-drain
   wire [7:0] lv = ~port4_pad_oe_out | port4_pad_out;
   uart_clk_a: assert property ($past(rst_n_in & async_serial_clock_en_in)
      |-> lv[0] == $past(async_serial_clock_drv_in)) else $error("uart clock lost");
   uart_txd_a: assert property ($past(rst_n_in & async_serial_txd_en_in)
      |-> lv[1] == $past(async_serial_txd_in)) else $error("uart txd lost");
   uart_rxd_a: assert property ($past(rst_n_in)
      |-> async_serial_rxd_out == $past(port4_pad_in[2])) else $error("uart rxd lost");
   sync1_clk_a: assert property ($past(rst_n_in & sync_serial1_clock_en_in)
      |-> lv[3] == $past(sync_serial1_clock_drv_in)) else $error("ch1 clock lost");
   sync0_clk_a: assert property ($past(rst_n_in & sync_serial0_clock_en_in)
      |-> lv[7] == $past(sync_serial0_clock_drv_in)) else $error("ch0 clock lost");
   p5_txd_a: assert property ($past(rst_n_in & sync_serial0_txd_en_in)
      |-> port5_pin0_oe_out == !$past(sync_serial0_txd_in)) else $error("ch0 txd lost");
   p5_low_a: assert property (port5_pin0_out == 1'h0) else $error("port5 drives high");
   trig_route_a: assert property ($past(rst_n_in) |-> converter_trigger_in_out
      == $past(converter_ext_trig_sel_in & port4_pad_in[6])) else $error("trigger lost");
endmodule
bind pmx_top pmx_monitor i_mon (.*);

// File: testbench/pmx_board.sv
// board model: pull-ups on the pads, bus device on the wait pin
`timescale 1ns/1ps
module pmx_board (
   input  wire logic [7:0] port4_pad_out, port4_pad_oe_out,                  // port 4 drive
   input  wire logic port3_pin6_out, port3_pin6_oe_out, port3_pin7_out, port3_pin7_oe_out,
   input  wire logic port5_pin0_out, port5_pin0_oe_out, ext_ready,           // ready source
   output logic [7:0] port4_pad_in,                                          // port 4 levels
   output logic port3_pin6_in, port3_pin7_in, port5_pin0_in                  // pad levels
);
   // released pads other than port-3 pin six float to the pull-up, so a lost drive shows as 1
   assign port4_pad_in = ~port4_pad_oe_out | port4_pad_out;
   assign port3_pin6_in = port3_pin6_oe_out ? port3_pin6_out : ext_ready;
   assign port3_pin7_in = ~port3_pin7_oe_out | port3_pin7_out;
   assign port5_pin0_in = ~port5_pin0_oe_out | port5_pin0_out;
endmodule

// File: testbench/pmx_top_tb_top.sv
// self-checking bench for the port multiplexer
`timescale 1ns/1ps
module pmx_top_tb_top;
   logic clk_in = '0, rst_n_in = '0, psel_in = '0, penable_in = '0, pwrite_in = '0;
   logic bus_clock_in = '0, ext_ready = '0, converter_ext_trig_sel_in = '0;
   logic twowire0_data_drv_in = '0, twowire0_en_in = '0;
   logic [7:0] paddr_in = '0;
   logic [3:0] pstrb_in = 4'hf;
   logic [31:0] pwdata_in = '0, prdata_out, rd;
   logic [11:0] pv = '0; // peripheral drive values and enables
   wire async_serial_clock_drv_in = pv[0], async_serial_clock_en_in = pv[1];
   wire async_serial_txd_in = pv[2], async_serial_txd_en_in = pv[3];
   wire sync_serial1_clock_drv_in = pv[4], sync_serial1_clock_en_in = pv[5];
   wire sync_serial1_txd_in = pv[6], sync_serial1_txd_en_in = pv[7];
   wire sync_serial0_clock_drv_in = pv[8], sync_serial0_clock_en_in = pv[9];
   wire sync_serial0_txd_in = pv[10], sync_serial0_txd_en_in = pv[11];
   logic pready_out, pslverr_out, bus_ready_out, async_serial_clock_out, async_serial_rxd_out;
   logic sync_serial1_clock_out, sync_serial1_rxd_out, sync_serial0_clock_out;
   logic converter_trigger_in_out, twowire0_data_out, port3_pin6_in, port3_pin6_out;
   logic port3_pin6_oe_out, port3_pin7_in, port3_pin7_out, port3_pin7_oe_out;
   logic port5_pin0_in, port5_pin0_out, port5_pin0_oe_out;
   logic [7:0] port4_pad_in, port4_pad_out, port4_pad_oe_out;
   int miscompares = 0, checked = 0, cyc = 0;
   pmx_top i_dut (.*);
   pmx_board i_board (.*);
   ////////////////////////////////////////////////////////////////
   initial forever #5 clk_in = ~clk_in;
   // watchdog: the whole run needs well under a hundred cycles
   always @(posedge clk_in) begin
      cyc <= cyc + 1;
      if (cyc == 2000) begin
         miscompares++;
         test_done();
      end
   end
   task automatic test_done;
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      checked++;
      if (s !== e) begin
         miscompares++;
         $display("[ERR] %0t seen %h expected %h", $time, s, e);
      end
   endtask
   // apb cycle: setup, then access held until pready
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_in);
      psel_in <= 1'h1;
      pwrite_in <= w;
      paddr_in <= a;
      pwdata_in <= d;
      @(posedge clk_in);
      penable_in <= 1'h1;
      do @(posedge clk_in); while (pready_out !== 1'h1);
      rd = prdata_out;
      psel_in <= 1'h0;
      penable_in <= 1'h0;
   endtask
   // pads lag their cause by a clock; sample away from the edge
   task automatic st;
      repeat (2) @(posedge clk_in);
      @(negedge clk_in);
   endtask
   initial begin
      repeat (3) @(posedge clk_in);
      rst_n_in <= 1'h1;
      apb(1'h0, pmx_pkg::ADDR_PORT5_LATCH, 32'h0);
      chk(rd, 32'h1);
      apb(1'h1, pmx_pkg::ADDR_PORT4_DIR, 32'hff);
      apb(1'h1, pmx_pkg::ADDR_PORT4_LATCH, 32'ha5);
      apb(1'h1, pmx_pkg::ADDR_PORT4_OD, 32'h0f);
      st();
      chk(32'(port4_pad_oe_out), 32'hfa);
      chk(32'(port4_pad_out), 32'ha0);
      $display("open-drain test done");
      apb(1'h1, pmx_pkg::ADDR_PORT4_DIR, 32'h00);
      pv <= 12'hafb;
      converter_ext_trig_sel_in <= 1'h1;
      st();
      chk(32'(port4_pad_oe_out), 32'h9b);
      chk(32'(port4_pad_out & port4_pad_oe_out), 32'h19);
      chk(32'({async_serial_rxd_out, converter_trigger_in_out}), 32'h3);
      chk(32'({async_serial_clock_out, sync_serial1_rxd_out}), 32'h3);
      chk(32'({sync_serial1_clock_out, sync_serial0_clock_out}), 32'h2);
      apb(1'h0, pmx_pkg::ADDR_PIN_LEVEL, 32'h0);
      chk(rd, 32'h7d80);
      $display("alternate test done");
      apb(1'h1, pmx_pkg::ADDR_PORT3_DIR, 32'hc0);
      apb(1'h1, pmx_pkg::ADDR_PORT3_LATCH, 32'h40);
      st();
      chk(32'({port3_pin6_oe_out, port3_pin6_out, port3_pin7_oe_out, port3_pin7_out}),
          32'he);
      apb(1'h1, pmx_pkg::ADDR_MODE, 32'h1);
      bus_clock_in <= 1'h1;
      st();
      chk(32'({port3_pin6_oe_out, bus_ready_out, port3_pin7_oe_out, port3_pin7_out}),
          32'h3);
      $display("bus mode test done");
      @(posedge clk_in);
      pv <= '0;
      twowire0_en_in <= 1'h1;
      st();
      chk(32'({port5_pin0_oe_out, port5_pin0_out, twowire0_data_out}), 32'h4);
      @(posedge clk_in);
      twowire0_data_drv_in <= 1'h1;
      st();
      chk(32'({port5_pin0_oe_out, port5_pin0_out, twowire0_data_out}), 32'h1);
      apb(1'h0, 8'h20, 32'h0);
      chk({rd[30:0], pslverr_out}, 32'h1);
      $display("two-wire and error test done");
      test_done();
   end
endmodule
